// ==== hw/twb_regs.svh ====
// Purpose: timing counts and fixed codes of the two-wire bus engine
// Assumes: 40 MHz system clock
// Notes: definitions only
`ifndef TWB_REGS_SVH
`define TWB_REGS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TWB_CLK_NS 25
`define TWB_HALF_NS 1250
`define TWB_HALF_CYC ((`TWB_HALF_NS) / (`TWB_CLK_NS))

// ----------------------------------------------------------------------
// reserved addresses and bit count before acknowledge
// ----------------------------------------------------------------------
`define TWB_GC_ADDR 7'h00
`define TWB_RSV_TOP 4'hF
`define TWB_LAST_BIT 4'h8

`endif

// ==== hw/twb_pkg.sv ====
// Purpose: state types of both bus ends
// Assumes: nothing
// Notes: each end keeps all its state in one packed struct
package twb_pkg;

	typedef enum logic [3:0] {
		M_IDLE = 4'h0,
		M_START = 4'h1,
		M_LOW = 4'h2,
		M_HIGH = 4'h3,
		M_LOAD = 4'h4,
		M_STOP1 = 4'h5,
		M_STOP2 = 4'h6,
		M_STOP3 = 4'h7,
		M_PARK = 4'h8,
		M_RS2 = 4'h9
	} twb_mst_st_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_ACK = 3'h2,
		S_RX = 3'h3,
		S_HOLD = 3'h4,
		S_TXLOAD = 3'h5,
		S_TX = 3'h6,
		S_TXACK = 3'h7
	} twb_slv_st_t;

	typedef struct packed {
		twb_mst_st_t st;
		logic [7:0] cnt;
		logic [8:0] sh;
		logic [8:0] rx;
		logic [3:0] bitc;
		logic [7:0] len;
		logic [6:0] addr;
		logic rd;
		logic hold;
		logic is_addr;
		logic scl_drv;
		logic sda_drv;
		logic scl_m1;
		logic scl_s;
		logic scl_p;
		logic sda_m1;
		logic sda_s;
		logic sda_p;
		logic busy;
		logic [7:0] rd_data;
		logic rd_valid;
		logic done;
		logic not_acknowledge;
	} twb_mst_t;

	typedef struct packed {
		twb_slv_st_t st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rw;
		logic mack;
		logic scl_drv;
		logic sda_drv;
		logic scl_m1;
		logic scl_s;
		logic scl_p;
		logic sda_m1;
		logic sda_s;
		logic sda_p;
		logic [1:0][7:0] fifo;
		logic wp;
		logic rp;
		logic [1:0] fcnt;
		logic hit;
		logic hit_rd;
		logic hit_gc;
		logic stopp;
	} twb_slv_t;

endpackage

// ==== hw/twb_if.sv ====
// Purpose: open-drain clock and data lines shared by both ends
// Assumes: pull-ups on both lines
// Notes: ext_* stand for further devices on the bus
interface twb_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic s_scl_oe;
	logic s_sda_oe;
	logic ext_scl_oe;
	logic ext_sda_oe;
	logic scl;
	logic sda;

	// ------------------------------------------------------------------
	// wired-and of all pull-downs
	// ------------------------------------------------------------------
	assign scl = ~(m_scl_oe | s_scl_oe | ext_scl_oe);
	assign sda = ~(m_sda_oe | s_sda_oe | ext_sda_oe);

	modport mst (output m_scl_oe, output m_sda_oe, input scl, input sda);
	modport slv (output s_scl_oe, output s_sda_oe, input scl, input sda);
endinterface

// ==== hw/twb_master.sv ====
// Purpose: bus master end of the two-wire bus engine
// Assumes: i_clk at 40 MHz, lines sampled through two flops
// Notes: one command is one transfer; hold ends it with a restart
//
// What the two-wire bus engine does
// - lines only pulled low or released
// - one clock pulse per data bit
// - data changes only while clock low
// - start and stop made with clock high
// - bus busy from start until stop
// - restart keeps the bus busy
// - address packet: seven bits, direction, acknowledge
// - direction one reads, zero writes
// - addressed slave acknowledges in ninth clock
// - unanswered address ends with stop or restart
// - address byte sent high bit first
// - all-zero address is general call
// - general-call write acknowledged by slaves with i_gc_en set
// - general call never sent with read
// - addresses 1111xxx reserved, never own address
// - data packet: byte high bit first, acknowledge
// - acknowledge low, not_acknowledge released in ninth
// - last received byte answered with not_acknowledge
// - master alone makes clock, start, stop
// - transfer has address and at least one byte
// - slave may stretch clock low, master waits
`include "twb_regs.svh"

module twb_master #(
	parameter logic [7:0] HALF = 8'(`TWB_HALF_CYC)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	twb_if.mst bus,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic [6:0] i_cmd_addr,
	input wire logic i_cmd_rd,
	input wire logic [7:0] i_cmd_len,
	input wire logic i_cmd_hold,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_done,
	output logic o_not_acknowledge,
	output logic o_busy
);
	import twb_pkg::*;

	localparam logic [7:0] MID = HALF >> 1;

	twb_mst_t r;
	twb_mst_t n;
	logic take;
	logic gc_rd;
	logic [8:0] rx_new;

	// ------------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------------
	assign o_cmd_ready = (r.st == M_IDLE && !r.busy)
		|| (r.st == M_PARK && r.cnt == HALF - 8'h01);
	assign o_wr_ready = (r.st == M_LOAD) && !r.rd;
	assign take = i_cmd_valid && o_cmd_ready;
	assign gc_rd = i_cmd_rd && (i_cmd_addr == `TWB_GC_ADDR);
	assign rx_new = {r.rx[7:0], r.sda_s};

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic fin;
		fin = 1'b0;
		n = r;
		n.scl_m1 = bus.scl;
		n.scl_s = r.scl_m1;
		n.scl_p = r.scl_s;
		n.sda_m1 = bus.sda;
		n.sda_s = r.sda_m1;
		n.sda_p = r.sda_s;
		n.rd_valid = 1'b0;
		n.done = 1'b0;
		n.not_acknowledge = 1'b0;
		n.cnt = 8'(r.cnt + 8'h01);
		if (r.scl_s && r.scl_p && r.sda_p && !r.sda_s) begin
			n.busy = 1'b1;
		end else if (r.scl_s && r.scl_p && !r.sda_p && r.sda_s) begin
			n.busy = 1'b0;
		end
		unique case (r.st)
			M_IDLE: begin
				n.scl_drv = 1'b0;
				n.sda_drv = 1'b0;
				n.cnt = 8'h00;
			end
			M_START: begin
				n.sda_drv = 1'b1;
				if (r.cnt == HALF - 8'h01) begin
					n.st = M_LOW;
					n.cnt = 8'h00;
					n.bitc = 4'h0;
				end
			end
			M_LOW: begin
				n.scl_drv = 1'b1;
				if (r.cnt == MID) begin
					n.sda_drv = ~r.sh[8];
				end
				if (r.cnt == HALF - 8'h01) begin
					n.st = M_HIGH;
					n.cnt = 8'h00;
				end
			end
			M_HIGH: begin
				n.scl_drv = 1'b0;
				if (!r.scl_s) begin
					n.cnt = r.cnt;
				end else if (r.cnt == HALF - 8'h01) begin
					n.cnt = 8'h00;
					n.rx = rx_new;
					n.sh = {r.sh[7:0], 1'b1};
					n.bitc = 4'(r.bitc + 4'h1);
					n.st = M_LOW;
					if (r.bitc == `TWB_LAST_BIT) begin
						n.st = M_LOAD;
						n.scl_drv = 1'b1;
						n.bitc = 4'h0;
						if (r.is_addr) begin
							n.is_addr = 1'b0;
							fin = r.sda_s;
						end else begin
							n.len = 8'(r.len - 8'h01);
							if (r.rd) begin
								n.rd_data = rx_new[8:1];
								n.rd_valid = 1'b1;
							end
							fin = (r.len == 8'h01) || (!r.rd && r.sda_s);
						end
						if (fin) begin
							n.done = 1'b1;
							n.not_acknowledge = r.sda_s && (r.is_addr || !r.rd);
							n.st = r.hold ? M_PARK : M_STOP1;
						end
					end
				end
			end
			M_LOAD: begin
				n.scl_drv = 1'b1;
				n.cnt = 8'h00;
				if (r.rd) begin
					n.sh = {8'hFF, r.len == 8'h01};
					n.st = M_LOW;
				end else if (i_wr_valid) begin
					n.sh = {i_wr_data, 1'b1};
					n.st = M_LOW;
				end
			end
			M_STOP1: begin
				n.scl_drv = 1'b1;
				if (r.cnt == MID) begin
					n.sda_drv = 1'b1;
				end
				if (r.cnt == HALF - 8'h01) begin
					n.st = M_STOP2;
					n.cnt = 8'h00;
				end
			end
			M_STOP2: begin
				n.scl_drv = 1'b0;
				if (!r.scl_s) begin
					n.cnt = r.cnt;
				end else if (r.cnt == HALF - 8'h01) begin
					n.sda_drv = 1'b0;
					n.st = M_STOP3;
					n.cnt = 8'h00;
				end
			end
			M_STOP3: begin
				if (r.cnt == HALF - 8'h01) begin
					n.st = M_IDLE;
				end
			end
			M_PARK: begin
				n.scl_drv = 1'b1;
				if (r.cnt == MID) begin
					n.sda_drv = 1'b0;
				end
				if (r.cnt == HALF - 8'h01) begin
					n.cnt = r.cnt;
				end
			end
			M_RS2: begin
				n.scl_drv = 1'b0;
				if (!r.scl_s) begin
					n.cnt = r.cnt;
				end else if (r.cnt == HALF - 8'h01) begin
					n.st = M_START;
					n.cnt = 8'h00;
				end
			end
			default: begin
				n.st = M_IDLE;
			end
		endcase
		if (take) begin
			n.addr = i_cmd_addr;
			n.rd = i_cmd_rd;
			n.hold = i_cmd_hold;
			n.len = (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
			n.sh = {i_cmd_addr, i_cmd_rd, 1'b1};
			n.is_addr = 1'b1;
			n.cnt = 8'h00;
			n.bitc = 4'h0;
			if (gc_rd) begin
				n.done = 1'b1;
				n.not_acknowledge = 1'b1;
				n.st = (r.st == M_PARK) ? M_STOP1 : M_IDLE;
			end else begin
				n.st = (r.st == M_PARK) ? M_RS2 : M_START;
			end
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= '0;
			r.scl_m1 <= 1'b1;
			r.scl_s <= 1'b1;
			r.scl_p <= 1'b1;
			r.sda_m1 <= 1'b1;
			r.sda_s <= 1'b1;
			r.sda_p <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign bus.m_scl_oe = r.scl_drv;
	assign bus.m_sda_oe = r.sda_drv;
	assign o_rd_data = r.rd_data;
	assign o_rd_valid = r.rd_valid;
	assign o_done = r.done;
	assign o_not_acknowledge = r.not_acknowledge;
	assign o_busy = r.busy;
endmodule

// ==== hw/twb_slave.sv ====
// Purpose: slave end of the two-wire bus engine
// Assumes: i_clk at least 16 times the bus clock
// Notes: received bytes pass a two-entry buffer; full buffer stretches clock
`include "twb_regs.svh"

module twb_slave (
	input wire logic i_clk,
	input wire logic i_rst_n,
	twb_if.slv bus,
	input wire logic i_en,
	input wire logic i_gc_en,
	input wire logic [6:0] i_own_addr,
	input wire logic i_not_acknowledge_rx,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic o_hit,
	output logic o_hit_rd,
	output logic o_hit_gc,
	output logic o_stop
);
	import twb_pkg::*;

	twb_slv_t r;
	twb_slv_t n;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic room;
	logic pop;

	// ------------------------------------------------------------------
	// address match
	// ------------------------------------------------------------------
	function automatic logic addr_hit(input logic [6:0] a, input logic rw,
		input logic en, input logic gc_en, input logic [6:0] own);
		logic own_ok;
		own_ok = (own != `TWB_GC_ADDR) && (own[6:3] != `TWB_RSV_TOP);
		addr_hit = (en && own_ok && a == own)
			|| (gc_en && a == `TWB_GC_ADDR && !rw);
	endfunction

	assign rise = r.scl_s && !r.scl_p;
	assign fall = !r.scl_s && r.scl_p;
	assign start = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
	assign stop = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
	assign room = r.fcnt != 2'h2;
	assign pop = o_rx_valid && i_rx_ready;
	assign o_rx_valid = r.fcnt != 2'h0;
	assign o_tx_ready = (r.st == S_TXLOAD) && (r.bitc == 4'h0);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic push;
		push = 1'b0;
		n = r;
		n.scl_m1 = bus.scl;
		n.scl_s = r.scl_m1;
		n.scl_p = r.scl_s;
		n.sda_m1 = bus.sda;
		n.sda_s = r.sda_m1;
		n.sda_p = r.sda_s;
		n.hit = 1'b0;
		n.stopp = 1'b0;
		unique case (r.st)
			S_IDLE: begin
				n.sda_drv = 1'b0;
				n.scl_drv = 1'b0;
			end
			S_ADDR, S_RX: begin
				if (rise) begin
					n.sh = {r.sh[6:0], r.sda_s};
					n.bitc = 4'(r.bitc + 4'h1);
				end else if (fall && r.bitc == `TWB_LAST_BIT) begin
					if (r.st == S_ADDR) begin
						if (addr_hit(r.sh[7:1], r.sh[0], i_en, i_gc_en, i_own_addr)) begin
							n.sda_drv = 1'b1;
							n.st = S_ACK;
							n.rw = r.sh[0];
							n.hit = 1'b1;
							n.hit_rd = r.sh[0];
							n.hit_gc = r.sh[7:1] == `TWB_GC_ADDR;
						end else begin
							n.st = S_IDLE;
						end
					end else if (i_not_acknowledge_rx) begin
						n.st = S_IDLE;
					end else if (room) begin
						push = 1'b1;
						n.sda_drv = 1'b1;
						n.st = S_ACK;
					end else begin
						n.scl_drv = 1'b1;
						n.st = S_HOLD;
					end
				end
			end
			S_HOLD: begin
				if (r.bitc == `TWB_LAST_BIT && room) begin
					push = 1'b1;
					n.sda_drv = 1'b1;
					n.bitc = 4'h9;
				end else if (r.bitc == 4'h9) begin
					n.scl_drv = 1'b0;
					n.st = S_ACK;
				end
			end
			S_ACK: begin
				if (fall) begin
					n.sda_drv = 1'b0;
					n.bitc = 4'h0;
					n.st = S_RX;
					if (r.rw) begin
						n.scl_drv = 1'b1;
						n.st = S_TXLOAD;
					end
				end
			end
			S_TXLOAD: begin
				n.scl_drv = 1'b1;
				if (r.bitc == 4'h0 && i_tx_valid) begin
					n.sh = i_tx_data;
					n.sda_drv = ~i_tx_data[7];
					n.bitc = 4'h1;
				end else if (r.bitc == 4'h1) begin
					n.scl_drv = 1'b0;
					n.bitc = 4'h0;
					n.st = S_TX;
				end
			end
			S_TX: begin
				if (rise) begin
					n.bitc = 4'(r.bitc + 4'h1);
				end else if (fall) begin
					if (r.bitc == `TWB_LAST_BIT) begin
						n.sda_drv = 1'b0;
						n.st = S_TXACK;
					end else begin
						n.sda_drv = ~r.sh[6];
						n.sh = {r.sh[6:0], 1'b0};
					end
				end
			end
			S_TXACK: begin
				if (rise) begin
					n.mack = r.sda_s;
				end else if (fall) begin
					n.bitc = 4'h0;
					n.st = r.mack ? S_IDLE : S_TXLOAD;
					n.scl_drv = !r.mack;
				end
			end
		endcase
		if (start) begin
			n.st = S_ADDR;
			n.bitc = 4'h0;
			n.sda_drv = 1'b0;
			n.scl_drv = 1'b0;
		end else if (stop) begin
			n.st = S_IDLE;
			n.sda_drv = 1'b0;
			n.scl_drv = 1'b0;
			n.stopp = 1'b1;
		end
		if (push) begin
			n.fifo[r.wp] = r.sh;
			n.wp = ~r.wp;
		end
		if (pop) begin
			n.rp = ~r.rp;
		end
		n.fcnt = 2'(r.fcnt + {1'b0, push} - {1'b0, pop});
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= '0;
			r.scl_m1 <= 1'b1;
			r.scl_s <= 1'b1;
			r.scl_p <= 1'b1;
			r.sda_m1 <= 1'b1;
			r.sda_s <= 1'b1;
			r.sda_p <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign bus.s_scl_oe = r.scl_drv;
	assign bus.s_sda_oe = r.sda_drv;
	assign o_rx_data = r.fifo[r.rp];
	assign o_hit = r.hit;
	assign o_hit_rd = r.hit_rd;
	assign o_hit_gc = r.hit_gc;
	assign o_stop = r.stopp;
endmodule

// ==== dv/twb_asserts.sv ====
// Purpose: bus-level checks on the shared clock and data lines
// Assumes: only the two ends and the ext pull-downs touch the lines
// Notes: helper counters track clock pulses per frame and high time per clock pulse
`include "twb_regs.svh"

module twb_asserts #(
	parameter logic [7:0] HALF = 8'(`TWB_HALF_CYC)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_scl_oe,
	input wire logic s_sda_oe,
	input wire logic ext_scl_oe,
	input wire logic ext_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q, sda_q, act, strt, stp;
	logic [7:0] cnt, sh, hcnt;

	// ----------------------------------------------------------------
	// frame tracking
	// ----------------------------------------------------------------
	assign strt = scl && scl_q && sda_q && !sda;
	assign stp = scl && scl_q && !sda_q && sda;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			act <= 1'b0;
			cnt <= 8'h00;
			sh <= 8'h00;
			hcnt <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			hcnt <= !scl ? 8'h00 : (hcnt == 8'hFF ? hcnt : hcnt + 8'h01);
			if (strt) begin
				cnt <= 8'h00;
				sh <= 8'h00;
				act <= 1'b1;
			end else if (scl && !scl_q) begin
				cnt <= cnt + 8'h01;
				sh <= {sh[6:0], sda};
			end
			if (stp) begin
				act <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_idle_released: assert property (
		!act && !strt |-> !m_scl_oe && !s_scl_oe && !s_sda_oe)
		else $error("line pulled low outside a frame");
	a_slave_data_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
		else $error("slave changed data while clock high");
	a_stop_frees_bus: assert property (
		scl && $past(scl) && $fell(m_sda_oe) |=> !act && scl)
		else $error("master data release with clock high not seen as stop");
	a_start_claims_bus: assert property (
		scl && $past(scl) && $rose(m_sda_oe) |=> act && !sda)
		else $error("master data pull with clock high not seen as start");
	a_stretch_only: assert property ($rose(s_scl_oe) |-> !$past(scl))
		else $error("slave pulled clock low while high");
	a_high_time: assert property (scl_q && !scl |-> hcnt >= HALF)
		else $error("clock high time shorter than master setting");
	a_frame_count: assert property (
		stp || (strt && act) |-> cnt % 8'h09 == 8'h01 && cnt > 8'h01)
		else $error("frame not whole nine-bit packets");
	a_gc_read_never: assert property (cnt == 8'h08 |-> sh != 8'h01)
		else $error("general call sent with read direction");
	a_reserved_not_acknowledge: assert property (
		cnt == 8'h08 && sh[7:4] == 4'hF && scl && !scl_q |-> sda)
		else $error("reserved address acknowledged");
	c_restart: cover property (strt && act);
endmodule

// ==== dv/tb_two_wire_bus_protocol.sv ====
// Purpose: self-checking bench of master and slave joined by one interface
// Assumes: master HALF shortened to 8 cycles
// Notes: driver queues expected results, monitor compares them
module tb_two_wire_bus_protocol;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic cmd_valid = 1'b0, cmd_rd = 1'b0, cmd_hold = 1'b0, wr_valid = 1'b0, en = 1'b1;
	logic gc_en = 1'b0, not_acknowledge_rx = 1'b0, rx_ready = 1'b1, tx_valid = 1'b0, slow = 1'b0;
	logic tw, tt;
	logic [6:0] cmd_addr = 7'h00, own = 7'h3C;
	logic [7:0] cmd_len = 8'h00, wr_data = 8'h00, tx_data = 8'h00, rd_data, rx_data;
	logic cmd_ready, wr_ready, rd_valid, done, not_acknowledge, busy, rx_valid, tx_ready;
	logic hit, stop, hit_rd, hit_gc;
	logic [31:0] rs = 32'hC92B6C91;
	logic [7:0] q_rx[$], q_rd[$], q_nk[$], q_ht[$], q_sp[$], wq[$], tq[$];
	int n_errors = 0, tests_run = 0, cyc = 0;

	twb_if bus();
	assign bus.ext_scl_oe = 1'b0;
	assign bus.ext_sda_oe = 1'b0;
	twb_master #(.HALF(8'h08)) i_twb_master(.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
		.i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_addr(cmd_addr),
		.i_cmd_rd(cmd_rd), .i_cmd_len(cmd_len), .i_cmd_hold(cmd_hold), .i_wr_data(wr_data),
		.i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_done(done), .o_not_acknowledge(not_acknowledge), .o_busy(busy));
	twb_slave i_twb_slave(.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus), .i_en(en),
		.i_gc_en(gc_en), .i_own_addr(own), .i_not_acknowledge_rx(not_acknowledge_rx), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_hit(hit), .o_hit_rd(hit_rd),
		.o_hit_gc(hit_gc), .o_stop(stop));
	twb_asserts #(.HALF(8'h08)) i_twb_asserts(.i_clk(i_clk), .i_rst_n(i_rst_n),
		.m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe), .s_scl_oe(bus.s_scl_oe),
		.s_sda_oe(bus.s_sda_oe), .ext_scl_oe(bus.ext_scl_oe), .ext_sda_oe(bus.ext_sda_oe),
		.scl(bus.scl), .sda(bus.sda));

	always #12.5 i_clk = ~i_clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic bad(input string m);
		n_errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic take(ref logic [7:0] q[$], input logic [7:0] got);
		tests_run++;
		if (q.size() == 0) begin
			bad("result with none expected");
		end else begin
			if (got !== q[0]) begin
				bad($sformatf("got %h expected %h", got, q[0]));
			end
			void'(q.pop_front());
		end
	endtask

	task automatic chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad($sformatf("flag %b expected %b", got, exp));
		end
	endtask

	task automatic end_of_test();
		if (q_rx.size() + q_rd.size() + q_nk.size() + q_ht.size() + q_sp.size() != 0) begin
			bad("expected results never came");
		end
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// mode 0 address refused, 1 full transfer, 2 data refused by slave
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] n,
		input logic hold, input logic [1:0] mode);
		int k;
		for (k = 0; k < ((n == 8'h00) ? 1 : n); k++) begin
			rs = xs(rs);
			if (mode != 2'h0 && !rd) begin
				wq.push_back(rs[7:0]);
			end
			if (mode == 2'h1 && !rd) begin
				q_rx.push_back(rs[7:0]);
			end
			if (mode == 2'h1 && rd) begin
				tq.push_back(rs[7:0]);
				q_rd.push_back(rs[7:0]);
			end
		end
		q_nk.push_back({7'h00, mode != 2'h1});
		if (mode != 2'h0) begin
			q_ht.push_back({6'h00, a == 7'h00, rd});
		end
		if (!hold && !(a == 7'h00 && rd)) begin
			q_sp.push_back(8'h01);
		end
		cmd_addr = a;
		cmd_rd = rd;
		cmd_len = n;
		cmd_hold = hold;
		cmd_valid = 1'b1;
		k = 0;
		do @(posedge i_clk); while (!cmd_ready && ++k < 5000);
		if (k >= 5000) bad("command never taken");
		#1 cmd_valid = 1'b0;
		k = 0;
		do @(posedge i_clk); while (!done && ++k < 20000);
		if (k >= 20000) bad("command never finished");
		#1;
	endtask

	// ----------------------------------------------------------------
	// stream feeders and result monitor
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		tw = wr_valid && wr_ready;
		tt = tx_valid && tx_ready;
		#1;
		if (tw) void'(wq.pop_front());
		if (tt) void'(tq.pop_front());
		wr_valid = wq.size() != 0;
		wr_data = wq.size() != 0 ? wq[0] : 8'h00;
		tx_valid = tq.size() != 0;
		tx_data = tq.size() != 0 ? tq[0] : 8'h00;
		cyc++;
		rx_ready = !slow || cyc[9:0] < 10'd4;
	end

	always @(posedge i_clk) begin
		if (rx_valid && rx_ready) take(q_rx, rx_data);
		if (rd_valid) take(q_rd, rd_data);
		if (done) take(q_nk, {7'h00, not_acknowledge});
		if (hit) take(q_ht, {6'h00, hit_gc, hit_rd});
		if (stop) take(q_sp, 8'h01);
	end

	initial begin
		#(25ns * 60000);
		bad("watchdog expired");
		end_of_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		repeat (6) @(posedge i_clk);
		#1 slow = 1'b1;
		xfer(own, 1'b0, 8'h04, 1'b0, 2'h1);
		slow = 1'b0;
		repeat (40) @(posedge i_clk);
		#1 chk(busy, 1'b0);
		xfer(own, 1'b1, 8'h03, 1'b0, 2'h1);
		chk(hit_rd, 1'b1);
		xfer(own, 1'b0, 8'h01, 1'b1, 2'h1);
		chk(busy, 1'b1);
		xfer(own, 1'b1, 8'h02, 1'b0, 2'h1);
		gc_en = 1'b1;
		xfer(7'h00, 1'b0, 8'h02, 1'b0, 2'h1);
		chk(hit_gc, 1'b1);
		xfer(7'h00, 1'b1, 8'h01, 1'b0, 2'h0);
		gc_en = 1'b0;
		xfer(7'h00, 1'b0, 8'h01, 1'b0, 2'h0);
		not_acknowledge_rx = 1'b1;
		xfer(own, 1'b0, 8'h00, 1'b0, 2'h2);
		not_acknowledge_rx = 1'b0;
		xfer(own ^ 7'h01, 1'b0, 8'h01, 1'b0, 2'h0);
		en = 1'b0;
		xfer(own, 1'b0, 8'h01, 1'b0, 2'h0);
		en = 1'b1;
		own = 7'h7A;
		xfer(7'h7A, 1'b0, 8'h01, 1'b0, 2'h0);
		repeat (40) @(posedge i_clk);
		end_of_test();
	end
endmodule
